/* inc/dbg_seq_pkg.sv */
// Constants and types for the debug sequencer next-state block.
// Assumes an APB host with word addressing: byte address = 4 * register index.
package dbg_seq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 4;
    localparam int INDEX_W = 6;

    // Register indices; the byte address is four times the index
    localparam logic [INDEX_W-1:0] IDX_DEBUG_CONTROL_ONE = 6'h20;
    localparam logic [INDEX_W-1:0] IDX_NEXT_SELECT = 6'h27;
    localparam logic [INDEX_W-1:0] IDX_COMP_CONTROL = 6'h28;
    localparam logic [INDEX_W-1:0] IDX_COMP_ADDR_HIGH = 6'h29;
    localparam logic [INDEX_W-1:0] IDX_COMP_ADDR_MID = 6'h2a;
    localparam logic [INDEX_W-1:0] IDX_COMP_ADDR_LOW = 6'h2b;
    localparam logic [INDEX_W-1:0] IDX_COMP_DATA_HIGH = 6'h2c;
    localparam logic [INDEX_W-1:0] IDX_COMP_DATA_LOW = 6'h2d;
    localparam logic [INDEX_W-1:0] IDX_COMP_DATA_HIGH_MASK = 6'h2e;
    localparam logic [INDEX_W-1:0] IDX_COMP_DATA_LOW_MASK = 6'h2f;

    // bank_select_field values
    localparam logic [1:0] BANK_STATE1 = 2'h0;
    localparam logic [1:0] BANK_STATE2 = 2'h1;
    localparam logic [1:0] BANK_STATE3 = 2'h2;
    localparam logic [1:0] BANK_FLAGS = 2'h3;

    // debug_control_one fields
    localparam int ARM_BIT = 7;
    localparam int STATE_LSB = 4;
    localparam int BANK_LSB = 0;

    // comparator_control field
    localparam int COMP_ENABLE_BIT = 0;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_STATE1,
        SEQ_STATE2,
        SEQ_STATE3,
        SEQ_FINAL
    } seq_state_t;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_STATE1,
        TGT_STATE2,
        TGT_STATE3,
        TGT_FINAL
    } target_t;
endpackage

/* rtl/debug_sequencer_next_state.sv */
// Debug sequencer next-state selection for State2 and State3, with match flags
// and the banked comparator register window, reached over APB.
// Assumes match inputs are synchronous one-bit-per-channel strobes and that an
// outside State1 decoder presents its own transition requests.
//
// Behaviour
// R1 - one address, four banked views by bank select
// R2 - bank 01 shows state2 next-state code
// R3 - bank 10 shows state3 next-state code
// R4 - code writes need matching bank, disarmed
// R5 - state2 codes 0-2: any match moves
// R6 - state2 codes 3-5: only channel 3
// R7 - state2 codes 6-8: paired channel targets
// R8 - state2 codes 9-b: paired channel targets
// R9 - state2 codes c, d as listed
// R10 - codes e, f never cause transitions
// R11 - state3 codes 0-2: any match moves
// R12 - state3 codes 3-5: channel 0 based
// R13 - state3 codes 6-8: only channel 1
// R14 - state3 codes 9-b: paired channel targets
// R15 - state3 codes c, d: final on one channel
// R16 - lowest matching channel wins ties
// R17 - final state beats every other target
// R18 - software enables comparators before matching
// R19 - four sticky flags survive session end
// R20 - flags read-only in bank 11, arming clears
// R21 - flags set independently, repeats harmless
// R22 - eight-byte comparator window per bank
// R23 - address-only comparators: data bytes zero
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

module debug_sequencer_next_state
    import dbg_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dbg_seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [dbg_seq_pkg::DATA_W-1:0] pwdata,
    output logic [dbg_seq_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dbg_seq_pkg::NUM_CH-1:0] match,
    input wire logic state1_go_valid,
    input wire dbg_seq_pkg::target_t state1_go_target,
    output dbg_seq_pkg::seq_state_t seq_state,
    output logic armed,
    output logic final_hit,
    output logic [3:0] state1_code,
    output logic [dbg_seq_pkg::NUM_CH-1:0] comp_enable,
    output logic [dbg_seq_pkg::NUM_CH-1:0][7:0] comp_control,
    output logic [dbg_seq_pkg::NUM_CH-1:0][23:0] comp_address,
    output logic [1:0][15:0] comp_data,
    output logic [1:0][15:0] comp_data_mask
);
    import dbg_seq_pkg::*;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic armed_reg;
    logic [1:0] bank_reg;
    logic [3:0] code1_reg;
    logic [3:0] code2_reg;
    logic [3:0] code3_reg;
    logic [NUM_CH-1:0] flags_reg;
    logic [NUM_CH-1:0][7:0] ctl_reg;
    logic [NUM_CH-1:0][23:0] addr_reg;
    logic [1:0][15:0] data_reg;
    logic [1:0][15:0] mask_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic final_hit_reg;

    logic [INDEX_W-1:0] index;
    logic mapped;
    logic wr_done;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic arm_write;
    logic disarm_write;
    logic [NUM_CH-1:0] live_match;
    logic [NUM_CH-1:0] comp_en;
    logic full_comp;
    logic comp_half;
    logic move_valid;
    target_t move_target;

    // Target of one channel for a code, in State2 or State3
    function automatic target_t chan_target(input logic in_s3, input logic [3:0] code,
                                            input int ch);
        target_t t;
        t = TGT_NONE;
        if (!in_s3)
        begin
            unique case (code)
                4'h0: t = TGT_STATE1; // see R5
                4'h1: t = TGT_STATE3; // see R5
                4'h2: t = TGT_FINAL; // see R5
                4'h3: t = (ch == 3) ? TGT_STATE1 : TGT_NONE; // see R6
                4'h4: t = (ch == 3) ? TGT_STATE3 : TGT_NONE; // see R6
                4'h5: t = (ch == 3) ? TGT_FINAL : TGT_NONE; // see R6
                4'h6: t = (ch == 0) ? TGT_STATE1 : (ch == 1) ? TGT_STATE3 : TGT_NONE; // see R7
                4'h7: t = (ch == 1) ? TGT_STATE3 : (ch == 0) ? TGT_FINAL : TGT_NONE; // see R7
                4'h8: t = (ch == 0) ? TGT_STATE1 : (ch == 2) ? TGT_STATE3 : TGT_NONE; // see R7
                4'h9: t = (ch == 2) ? TGT_STATE3 : (ch == 0) ? TGT_FINAL : TGT_NONE; // see R8
                4'ha: t = (ch == 1) ? TGT_STATE1 : (ch == 3) ? TGT_STATE3 : TGT_NONE; // see R8
                4'hb: t = (ch == 3) ? TGT_STATE3 : (ch == 1) ? TGT_FINAL : TGT_NONE; // see R8
                4'hc: t = (ch == 2) ? TGT_STATE1 : (ch == 3) ? TGT_FINAL : TGT_NONE; // see R9
                4'hd: t = (ch == 2) ? TGT_NONE : TGT_FINAL; // see R9
                default: t = TGT_NONE; // see R10
            endcase
        end
        else
        begin
            unique case (code)
                4'h0: t = TGT_STATE1; // see R11
                4'h1: t = TGT_STATE2; // see R11
                4'h2: t = TGT_FINAL; // see R11
                4'h3: t = (ch == 0) ? TGT_STATE1 : TGT_NONE; // see R12
                4'h4: t = (ch == 0) ? TGT_STATE2 : TGT_NONE; // see R12
                4'h5: t = (ch == 0) ? TGT_FINAL : (ch == 1) ? TGT_STATE1 : TGT_NONE; // see R12
                4'h6: t = (ch == 1) ? TGT_STATE1 : TGT_NONE; // see R13
                4'h7: t = (ch == 1) ? TGT_STATE2 : TGT_NONE; // see R13
                4'h8: t = (ch == 1) ? TGT_FINAL : TGT_NONE; // see R13
                4'h9: t = (ch == 2) ? TGT_STATE2 : (ch == 0) ? TGT_FINAL : TGT_NONE; // see R14
                4'ha: t = (ch == 1) ? TGT_STATE1 : (ch == 3) ? TGT_STATE2 : TGT_NONE; // see R14
                4'hb: t = (ch == 3) ? TGT_STATE2 : (ch == 1) ? TGT_FINAL : TGT_NONE; // see R14
                4'hc: t = (ch == 2) ? TGT_FINAL : TGT_NONE; // see R15
                4'hd: t = (ch == 3) ? TGT_FINAL : TGT_NONE; // see R15
                default: t = TGT_NONE; // see R10
            endcase
        end
        return t;
    endfunction

    // Comparators of the first and third bank carry data and mask bytes
    function automatic logic has_data(input logic [1:0] bank);
        return !bank[0];
    endfunction

    assign index = paddr[ADDR_W-1:2];
    assign mapped = (paddr[1:0] == 2'h0)
        && ((index == IDX_DEBUG_CONTROL_ONE)
        || (index >= IDX_NEXT_SELECT && index <= IDX_COMP_DATA_LOW_MASK));
    assign wr_done = psel && penable && pready_reg && pwrite && mapped;
    assign wbyte = pwdata[7:0];
    assign arm_write = wr_done && (index == IDX_DEBUG_CONTROL_ONE) && wbyte[ARM_BIT];
    assign disarm_write = wr_done && (index == IDX_DEBUG_CONTROL_ONE) && !wbyte[ARM_BIT];
    assign full_comp = has_data(bank_reg);
    assign comp_half = bank_reg[1];

    // A match counts only on an enabled comparator
    always_comb
    begin
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            comp_en[ch] = ctl_reg[ch][COMP_ENABLE_BIT];
        end
        live_match = match & comp_en; // see R18
    end

    // Final beats all; otherwise the lowest matching channel decides
    always_comb
    begin
        logic in_s3;
        logic [3:0] code;
        target_t t;
        in_s3 = (state_reg == SEQ_STATE3);
        code = in_s3 ? code3_reg : code2_reg;
        move_valid = 1'b0;
        move_target = TGT_NONE;
        t = TGT_NONE;
        if (state_reg == SEQ_STATE2 || state_reg == SEQ_STATE3)
        begin
            for (int ch = NUM_CH - 1; ch >= 0; ch--)
            begin
                t = chan_target(in_s3, code, ch);
                if (live_match[ch] && t != TGT_NONE)
                begin
                    move_valid = 1'b1;
                    move_target = t; // see R16
                end
            end
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                if (live_match[ch] && chan_target(in_s3, code, ch) == TGT_FINAL)
                begin
                    move_target = TGT_FINAL; // see R17
                end
            end
        end
        else if (state_reg == SEQ_STATE1 && state1_go_valid
                 && state1_go_target != TGT_STATE1)
        begin
            move_valid = state1_go_target != TGT_NONE;
            move_target = state1_go_target;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        if (arm_write)
        begin
            state_next = SEQ_STATE1;
        end
        else if (disarm_write)
        begin
            state_next = SEQ_IDLE;
        end
        else if (move_valid)
        begin
            unique case (move_target)
                TGT_STATE1: state_next = SEQ_STATE1;
                TGT_STATE2: state_next = SEQ_STATE2;
                TGT_STATE3: state_next = SEQ_STATE3;
                TGT_FINAL: state_next = SEQ_FINAL;
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= SEQ_IDLE;
            armed_reg <= 1'b0;
            final_hit_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            final_hit_reg <= (state_next == SEQ_FINAL) && (state_reg != SEQ_FINAL);
            if (arm_write)
            begin
                armed_reg <= 1'b1;
            end
            else if (disarm_write || state_next == SEQ_FINAL)
            begin
                armed_reg <= 1'b0;
            end
        end
    end

    // Flags: arming clears; a match in the same cycle sets only when already armed
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_reg <= FLAGS_RESET;
        end
        else if (arm_write)
        begin
            flags_reg <= armed_reg ? live_match : FLAGS_RESET; // see R20
        end
        else if (armed_reg)
        begin
            flags_reg <= flags_reg | live_match; // see R19, R21
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bank_reg <= 2'h0;
            code1_reg <= CODE_RESET;
            code2_reg <= CODE_RESET;
            code3_reg <= CODE_RESET;
        end
        else if (wr_done)
        begin
            if (index == IDX_DEBUG_CONTROL_ONE)
            begin
                bank_reg <= wbyte[BANK_LSB +: 2];
            end
            if (index == IDX_NEXT_SELECT && !armed_reg)
            begin
                unique case (bank_reg)
                    BANK_STATE1: code1_reg <= wbyte[3:0];
                    BANK_STATE2: code2_reg <= wbyte[3:0]; // see R4
                    BANK_STATE3: code3_reg <= wbyte[3:0]; // see R4
                    BANK_FLAGS: code1_reg <= code1_reg; // see R20
                endcase
            end
        end
    end

    // Comparator window writes go to the bank-selected comparator
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_reg <= '0;
            addr_reg <= '0;
            data_reg <= '0;
            mask_reg <= '0;
        end
        else if (wr_done && !armed_reg)
        begin
            unique case (index)
                IDX_COMP_CONTROL: ctl_reg[bank_reg] <= wbyte; // see R22
                IDX_COMP_ADDR_HIGH: addr_reg[bank_reg][23:16] <= wbyte;
                IDX_COMP_ADDR_MID: addr_reg[bank_reg][15:8] <= wbyte;
                IDX_COMP_ADDR_LOW: addr_reg[bank_reg][7:0] <= wbyte;
                IDX_COMP_DATA_HIGH:
                    if (full_comp) data_reg[comp_half][15:8] <= wbyte; // see R23
                IDX_COMP_DATA_LOW:
                    if (full_comp) data_reg[comp_half][7:0] <= wbyte;
                IDX_COMP_DATA_HIGH_MASK:
                    if (full_comp) mask_reg[comp_half][15:8] <= wbyte;
                IDX_COMP_DATA_LOW_MASK:
                    if (full_comp) mask_reg[comp_half][7:0] <= wbyte;
                default: ctl_reg <= ctl_reg;
            endcase
        end
    end

    always_comb
    begin
        rbyte = BYTE_RESET;
        unique case (index)
            IDX_DEBUG_CONTROL_ONE:
                rbyte = {armed_reg, state_reg, 2'h0, bank_reg};
            IDX_NEXT_SELECT:
                unique case (bank_reg) // see R1
                    BANK_STATE1: rbyte = {4'h0, code1_reg};
                    BANK_STATE2: rbyte = {4'h0, code2_reg}; // see R2
                    BANK_STATE3: rbyte = {4'h0, code3_reg}; // see R3
                    BANK_FLAGS: rbyte = {4'h0, flags_reg}; // see R20
                endcase
            IDX_COMP_CONTROL: rbyte = ctl_reg[bank_reg];
            IDX_COMP_ADDR_HIGH: rbyte = addr_reg[bank_reg][23:16];
            IDX_COMP_ADDR_MID: rbyte = addr_reg[bank_reg][15:8];
            IDX_COMP_ADDR_LOW: rbyte = addr_reg[bank_reg][7:0];
            IDX_COMP_DATA_HIGH: rbyte = full_comp ? data_reg[comp_half][15:8] : 8'h00; // see R23
            IDX_COMP_DATA_LOW: rbyte = full_comp ? data_reg[comp_half][7:0] : 8'h00;
            IDX_COMP_DATA_HIGH_MASK: rbyte = full_comp ? mask_reg[comp_half][15:8] : 8'h00;
            IDX_COMP_DATA_LOW_MASK: rbyte = full_comp ? mask_reg[comp_half][7:0] : 8'h00;
            default: rbyte = BYTE_RESET;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end
        else if (psel && penable && !pready_reg)
        begin
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg <= (mapped && !pwrite) ? {24'h000000, rbyte} : '0;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign seq_state = state_reg;
    assign armed = armed_reg;
    assign final_hit = final_hit_reg;
    assign state1_code = code1_reg;
    assign comp_enable = comp_en;
    assign comp_control = ctl_reg;
    assign comp_address = addr_reg;
    assign comp_data = data_reg;
    assign comp_data_mask = mask_reg;
endmodule

/* verification/match_source.sv */
// Model of the comparator match channels that feed the sequencer.
// Assumes the bench asks for a strobe one cycle ahead by raising fire.
`timescale 1ns/1ps
module match_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [3:0] pattern,
    output logic [3:0] match
);
    // One-cycle strobe, quiet otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            match <= 4'h0;
        else
            match <= fire ? pattern : 4'h0;
    end
endmodule

/* verification/debug_sequencer_next_state_assertions.sv */
// Port-level checks of the debug sequencer next-state block.
// Assumes the design package is compiled first; attached by bind below.
`timescale 1ns/1ps
module debug_sequencer_next_state_checker
    import dbg_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dbg_seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [dbg_seq_pkg::DATA_W-1:0] pwdata,
    input wire logic [dbg_seq_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [dbg_seq_pkg::NUM_CH-1:0] match,
    input wire dbg_seq_pkg::seq_state_t seq_state,
    input wire logic armed,
    input wire logic final_hit,
    input wire logic [dbg_seq_pkg::NUM_CH-1:0] comp_enable,
    input wire logic [dbg_seq_pkg::NUM_CH-1:0][7:0] comp_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_done;
    logic ctl_wr;
    logic arm_bit;
    logic mapped;
    assign wr_done = psel && penable && pready && pwrite;
    assign ctl_wr = wr_done && paddr == 8'h80;
    assign arm_bit = pwdata[ARM_BIT];
    assign mapped = paddr == 8'h80 || paddr == 8'h9c
        || (paddr >= 8'ha0 && paddr <= 8'hbc && paddr[1:0] == 2'h0);

    chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_unmapped_err: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("slave error does not match address map");
    chk_arm_write: assert property (ctl_wr |=> armed == $past(arm_bit)
        && seq_state == ($past(arm_bit) ? SEQ_STATE1 : SEQ_IDLE))
        else $error("arm write did not set state");
    chk_hold_unqualified: assert property ((seq_state == SEQ_STATE2
        || seq_state == SEQ_STATE3) && (match & comp_enable) == 4'h0 && !ctl_wr
        |=> $stable(seq_state))
        else $error("state moved without a qualified match");
    chk_final_pulse: assert property (seq_state != SEQ_FINAL ##1 seq_state == SEQ_FINAL
        |-> final_hit)
        else $error("final entry without pulse");
    chk_final_only: assert property (final_hit |-> seq_state == SEQ_FINAL && !armed)
        else $error("final pulse outside final state");
    chk_armed_window: assert property (armed && wr_done && paddr >= 8'ha0
        |=> $stable(comp_control))
        else $error("comparator written while armed");
    chk_enable_bits: assert property (comp_enable == {comp_control[3][0],
        comp_control[2][0], comp_control[1][0], comp_control[0][0]})
        else $error("comparator enable differs from control bit");
endmodule

bind debug_sequencer_next_state debug_sequencer_next_state_checker
    debug_sequencer_next_state_checker_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .match(match), .seq_state(seq_state),
    .armed(armed), .final_hit(final_hit), .comp_enable(comp_enable),
    .comp_control(comp_control));

/* verification/tb_debug_sequencer_next_state.sv */
// Self-checking bench for the debug sequencer next-state block over APB.
// Assumes the design package, the match model and the checker are compiled first.
`timescale 1ns/1ps
module tb_debug_sequencer_next_state;
    import dbg_seq_pkg::*;
    logic clk, rst, psel, penable, pwrite, fire, go_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, rerr;
    logic [3:0] match, pat, en;
    logic [3:0] s1code;
    logic [3:0][23:0] caddr;
    logic [1:0][15:0] cdata, cmask;
    target_t go_tgt;
    seq_state_t seq_state;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Stage, code, match pattern, expected state
    localparam logic [15:0] CASES [40] = '{16'h2041, 16'h2123, 16'h2183, 16'h2372,
        16'h2381, 16'h2483, 16'h2584, 16'h2631, 16'h2734, 16'h2843, 16'h2954, 16'h2a83,
        16'h2aa1, 16'h2ba4, 16'h2c41, 16'h2d42, 16'h2d14, 16'h2ef2, 16'h2ff2, 16'h3011,
        16'h3122, 16'h3214, 16'h3311, 16'h3323, 16'h3412, 16'h3534, 16'h3521, 16'h3621,
        16'h3722, 16'h3824, 16'h3813, 16'h3942, 16'h3a82, 16'h3ba4, 16'h3c44, 16'h3d84,
        16'h3d43, 16'h3ef3, 16'h3af1, 16'h3ff3};

    debug_sequencer_next_state debug_sequencer_next_state_i (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .match(match),
        .state1_go_valid(go_valid), .state1_go_target(go_tgt), .seq_state(seq_state),
        .armed(), .final_hit(), .state1_code(s1code), .comp_enable(), .comp_control(),
        .comp_address(caddr), .comp_data(cdata), .comp_data_mask(cmask));
    match_source match_source_i (.clk(clk), .rst(rst), .fire(fire), .pattern(pat),
        .match(match));

    task complete_run();
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task cmp_state(input string name, input seq_state_t exp, input seq_state_t got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; entered and left just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp_word("read data", exp, rdat);
    endtask

    task run_case(input logic [15:0] c);
        logic [31:0] bk;
        bk = 32'(c[15:12]) - 32'h1;
        apb(1'b1, 8'h80, bk);
        apb(1'b1, 8'h9c, 32'(c[11:8]));
        apb(1'b1, 8'h80, 32'h80 | bk);
        go_valid <= 1'b1;
        go_tgt <= target_t'(c[14:12]);
        @(posedge clk);
        go_valid <= 1'b0;
        @(posedge clk);
        cmp_state("entry state", seq_state_t'(c[14:12]), seq_state);
        fire <= 1'b1;
        pat <= c[7:4];
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_state("next state", seq_state_t'(c[2:0]), seq_state);
        apb(1'b1, 8'h80, 32'h3);
        rd(8'h9c, {28'h0, c[7:4] & en});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            complete_run();
        end
    end

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, fire, go_valid} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pat = 4'h0;
        en = 4'h0;
        go_tgt = TGT_NONE;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h80, 32'h0);
        rd(8'h9c, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        cmp_word("unmapped error", 32'h1, {31'h0, rerr});
        run_case(16'h2012);
        for (int b = 0; b < 4; b++)
        begin
            apb(1'b1, 8'h80, 32'(b));
            apb(1'b1, 8'ha0, 32'h1);
            apb(1'b1, 8'ha4, 32'h10 + 32'(b));
            apb(1'b1, 8'hb0, 32'h5a + 32'(b));
            apb(1'b1, 8'hbc, 32'h30 + 32'(b));
            rd(8'hb0, b[0] ? 32'h0 : 32'h5a + 32'(b));
            rd(8'ha4, 32'h10 + 32'(b));
        end
        cmp_word("comp address c", 32'h00120000, {8'h0, caddr[2]});
        cmp_word("comp data a", 32'h00005a00, {16'h0, cdata[0]});
        cmp_word("comp data c", 32'h00005c00, {16'h0, cdata[1]});
        cmp_word("comp mask c", 32'h00000032, {16'h0, cmask[1]});
        apb(1'b1, 8'h80, 32'h0);
        apb(1'b1, 8'h9c, 32'h6);
        rd(8'h9c, 32'h6);
        cmp_word("state1 code", 32'h6, {28'h0, s1code});
        en = 4'hf;
        apb(1'b1, 8'h80, 32'h1);
        apb(1'b1, 8'h9c, 32'h5);
        apb(1'b1, 8'h80, 32'h81);
        apb(1'b1, 8'h9c, 32'h9);
        apb(1'b1, 8'ha4, 32'hff);
        apb(1'b1, 8'h80, 32'h2);
        apb(1'b1, 8'h9c, 32'h7);
        rd(8'h9c, 32'h7);
        rd(8'ha4, 32'h12);
        apb(1'b1, 8'h80, 32'h1);
        rd(8'h9c, 32'h5);
        foreach (CASES[i])
            run_case(CASES[i]);
        apb(1'b1, 8'h9c, 32'h0);
        rd(8'h9c, 32'hf);
        complete_run();
    end
endmodule
